/* rtl/svs_pkg.sv */
package svs_pkg;
  // register map; printed offset 0x55 is not word aligned, so it is an index
  localparam logic [7:0]  SVS_CTRL_INDEX      = 8'h55;
  localparam logic [31:0] SVS_CTRL_ADDR       = 32'h00000154;
  localparam int          SVS_FIELD_FLAG      = 0;
  localparam int          SVS_FIELD_LEVEL     = 1;
  localparam int          SVS_FIELD_ACTIVE    = 2;
  localparam int          SVS_FIELD_RST_ON    = 3;
  localparam int          SVS_FIELD_SEL_LO    = 4;
  localparam int          SVS_FIELD_SEL_HI    = 7;
  localparam logic [3:0]  SVS_SEL_OFF         = 4'h0;
  localparam logic [3:0]  SVS_SEL_EXTERNAL    = 4'hf;
  localparam logic [3:0]  SVS_SEL_RESET       = 4'h0;
  localparam logic        SVS_RST_ON_RESET    = 1'b0;
  localparam logic        SVS_FLAG_RESET      = 1'b0;
  // delays in ns and derived cycle counts at 40 MHz
  localparam int          SVS_CLK_HZ          = 40000000;
  localparam int          SVS_STARTUP_NS      = 50000;
  localparam int          SVS_SETTLE_NS       = 12000;
  localparam int          SVS_STARTUP_CYCLES  = (SVS_STARTUP_NS * (SVS_CLK_HZ / 1000000) + 999) / 1000;
  localparam int          SVS_SETTLE_CYCLES   = (SVS_SETTLE_NS * (SVS_CLK_HZ / 1000000)) / 1000;
  localparam int          SVS_CNT_W           = 16;
  localparam logic [1:0]  SVS_HTRANS_NONSEQ   = 2'b10;
endpackage : svs_pkg

/* rtl/svs_sync.sv */
`timescale 1ns/1ps
module svs_sync (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic din,
  output logic      dout
);
  logic meta;

  always_ff @(posedge clk) begin
    if (srst) begin
      meta <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule : svs_sync

/* rtl/svs_delay.sv */
`timescale 1ns/1ps
module svs_delay #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic         start,
  input  wire logic [W-1:0] load,
  output logic              busy
);
  logic [W-1:0] cnt;

  // restart wins: a new change during a delay begins a fresh wait
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt  <= '0;
      busy <= 1'b0;
    end else if (start) begin
      cnt  <= load;
      busy <= 1'b1;
    end else if (cnt > W'(1)) begin
      cnt <= cnt - W'(1);
    end else begin
      cnt  <= '0;
      busy <= 1'b0;
    end
  end
endmodule : svs_delay

/* rtl/svs_ctrl.sv */
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ps
// Notes on behaviour
// - off while select is zero, monitoring for any non-zero select.
// - monitor-active bit is status only; writes to it are ignored.
// - top select code routes external sense input to the comparator.
// - code zero off, codes one to fourteen supply levels, fifteen external.
// - low comparator while active and not settling sets the flag.
// - reset-on-low set makes a low event raise power-on reset.
// - flag stays latched until software clears; live condition sets it again.
// - brownout reset or srst clears the flag; otherwise only software clears it.
// - zero to non-zero select change starts a fifty microsecond delay.
// - non-zero to other non-zero change starts a twelve microsecond delay.
// - during delays no flag, no reset, monitor-active reads zero.
// - brownout reset returns select to zero.
// - control fields and flag reset by brownout or srst only, not power-up clear.
// - comparator level bit shows the live comparator output.
module svs_ctrl
  import svs_pkg::*;
#(
  parameter int STARTUP_CYCLES = SVS_STARTUP_CYCLES,
  parameter int SETTLE_CYCLES  = SVS_SETTLE_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        brownout_reset,
  input  wire logic        power_up_clear,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        comparator_out,
  output logic             use_external_sense,
  output logic [3:0]       threshold_level,
  output logic             supervisor_enable,
  output logic             por_request,
  output logic             monitor_active,
  output logic             low_voltage_flag,
  output logic             comparator_level
);
  typedef enum logic [2:0] {
    SVS_ST_OFF    = 3'b001,
    SVS_ST_SETTLE = 3'b010,
    SVS_ST_WATCH  = 3'b100
  } svs_state_t;

  // kind of select change, which decides the delay to apply
  typedef enum logic [3:0] {
    SVS_TR_NONE    = 4'b0001,
    SVS_TR_STARTUP = 4'b0010,
    SVS_TR_SETTLE  = 4'b0100,
    SVS_TR_OFF     = 4'b1000
  } svs_trans_t;

  svs_state_t state;
  svs_state_t next_state;
  logic [3:0] threshold_select;
  logic       reset_on_low;
  logic       cmp_sync;
  logic       wr_pend;
  logic       rd_pend;
  logic       wr_hit;
  logic       wr_clear_flag;
  logic [3:0] next_select;
  logic       sel_change;
  logic       delay_start;
  logic       delay_busy;
  logic [SVS_CNT_W-1:0] delay_load;
  logic       low_event;
  svs_trans_t trans_kind;
  logic [7:0] status_word;
  logic [31:0] rd_word;

  function automatic logic svs_hit(input logic [31:0] a);
    return a == SVS_CTRL_ADDR;
  endfunction : svs_hit

  // classify a select write by the delay that it needs
  function automatic svs_trans_t svs_classify(input logic       change,
                                              input logic [3:0] cur,
                                              input logic [3:0] nxt);
    svs_trans_t kind;
    kind = SVS_TR_NONE;
    if (change) begin
      if (nxt == SVS_SEL_OFF) begin
        kind = SVS_TR_OFF;
      end else if (cur == SVS_SEL_OFF) begin
        kind = SVS_TR_STARTUP;
      end else begin
        kind = SVS_TR_SETTLE;
      end
    end
    return kind;
  endfunction : svs_classify

  // brownout and srst both initialise control state; power_up_clear is ignored
  wire logic ctl_rst = srst | brownout_reset;

  svs_sync u_sync (
    .clk  (clk),
    .srst (srst),
    .din  (comparator_out),
    .dout (cmp_sync)
  );

  // ahb-lite slave: zero wait states, always OKAY
  always_ff @(posedge clk) begin
    if (srst) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
    end else if (hready) begin
      wr_pend <= hsel & htrans[1] & hwrite & svs_hit(haddr);
      rd_pend <= hsel & htrans[1] & ~hwrite;
    end else begin
      wr_pend <= wr_pend;
      rd_pend <= rd_pend;
    end
  end

  logic rd_hit_next;
  assign rd_hit_next = hsel & htrans[1] & ~hwrite & hready & svs_hit(haddr);

  always_ff @(posedge clk) begin
    if (srst) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  assign wr_hit        = wr_pend;
  assign next_select   = hwdata[SVS_FIELD_SEL_HI:SVS_FIELD_SEL_LO];
  assign wr_clear_flag = wr_hit & ~hwdata[SVS_FIELD_FLAG];
  assign sel_change    = wr_hit & (next_select != threshold_select);

  always_ff @(posedge clk) begin
    if (ctl_rst) begin
      threshold_select <= SVS_SEL_RESET;
    end else if (wr_hit) begin
      threshold_select <= next_select;
    end
  end

  // bit 2 of a written word is dropped: monitor_active is status only
  always_ff @(posedge clk) begin
    if (ctl_rst) begin
      reset_on_low <= SVS_RST_ON_RESET;
    end else if (wr_hit) begin
      reset_on_low <= hwdata[SVS_FIELD_RST_ON];
    end
  end

  // a rewrite of the same select is no change and restarts no delay
  assign trans_kind = svs_classify(sel_change, threshold_select, next_select);

  // pick delay from the transition kind
  always_comb begin
    delay_start = 1'b0;
    delay_load  = SVS_CNT_W'(SETTLE_CYCLES);
    case (trans_kind)
      SVS_TR_STARTUP: begin
        delay_start = 1'b1;
        delay_load  = SVS_CNT_W'(STARTUP_CYCLES);
      end
      SVS_TR_SETTLE: begin
        delay_start = 1'b1;
        delay_load  = SVS_CNT_W'(SETTLE_CYCLES);
      end
      default: begin
        delay_start = 1'b0;
      end
    endcase
  end

  svs_delay #(
    .W (SVS_CNT_W)
  ) u_delay (
    .clk   (clk),
    .srst  (ctl_rst),
    .start (delay_start),
    .load  (delay_load),
    .busy  (delay_busy)
  );

  always_comb begin
    next_state = state;
    case (state)
      SVS_ST_OFF: begin
        if (delay_start) begin
          next_state = SVS_ST_SETTLE;
        end
      end
      SVS_ST_SETTLE: begin
        if (threshold_select == SVS_SEL_OFF) begin
          next_state = SVS_ST_OFF;
        end else if (!delay_start && !delay_busy) begin
          next_state = SVS_ST_WATCH;
        end
      end
      SVS_ST_WATCH: begin
        if (trans_kind == SVS_TR_OFF) begin
          next_state = SVS_ST_OFF;
        end else if (delay_start) begin
          next_state = SVS_ST_SETTLE;
        end
      end
      default: begin
        next_state = SVS_ST_OFF;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (ctl_rst) begin
      state <= SVS_ST_OFF;
    end else begin
      state <= next_state;
    end
  end

  // comparator output low means supply below threshold
  assign low_event = (state == SVS_ST_WATCH) && !delay_busy && !cmp_sync;

  // set wins over a software clear, so a persisting condition re-flags at once
  always_ff @(posedge clk) begin
    if (ctl_rst) begin
      low_voltage_flag <= SVS_FLAG_RESET;
    end else if (low_event) begin
      low_voltage_flag <= 1'b1;
    end else if (wr_clear_flag) begin
      low_voltage_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (ctl_rst) begin
      por_request <= 1'b0;
    end else begin
      por_request <= reset_on_low & low_event;
    end
  end

  // taken from next_state so the bit drops on the very edge a delay starts
  always_ff @(posedge clk) begin
    if (ctl_rst) begin
      monitor_active <= 1'b0;
    end else begin
      monitor_active <= (next_state == SVS_ST_WATCH);
    end
  end

  always_ff @(posedge clk) begin
    if (ctl_rst) begin
      supervisor_enable <= 1'b0;
    end else begin
      supervisor_enable <= (threshold_select != SVS_SEL_OFF);
    end
  end

  // analog side swaps its input only from this registered copy
  always_ff @(posedge clk) begin
    if (ctl_rst) begin
      use_external_sense <= 1'b0;
    end else begin
      use_external_sense <= (threshold_select == SVS_SEL_EXTERNAL);
    end
  end

  always_ff @(posedge clk) begin
    if (ctl_rst) begin
      threshold_level <= SVS_SEL_OFF;
    end else begin
      threshold_level <= threshold_select;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      comparator_level <= 1'b0;
    end else begin
      comparator_level <= cmp_sync;
    end
  end

  // status word in register bit order
  always_comb begin
    status_word                                    = 8'h00;
    status_word[SVS_FIELD_SEL_HI:SVS_FIELD_SEL_LO] = threshold_select;
    status_word[SVS_FIELD_RST_ON]                  = reset_on_low;
    status_word[SVS_FIELD_ACTIVE]                  = monitor_active;
    status_word[SVS_FIELD_LEVEL]                   = cmp_sync;
    status_word[SVS_FIELD_FLAG]                    = low_voltage_flag;
  end

  // upper bus lanes carry no field and read as zero
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_rd_bit
      if (gi < 8) begin : g_field
        assign rd_word[gi] = status_word[gi];
      end else begin : g_pad
        assign rd_word[gi] = 1'b0;
      end
    end
  endgenerate

  // read data registered in the address phase; flag shown is pre-write value
  // so a read cannot see a clear that lands in the same data phase
  always_ff @(posedge clk) begin
    if (srst) begin
      hrdata <= 32'h00000000;
    end else if (rd_hit_next) begin
      hrdata <= rd_word;
    end else if (hready) begin
      hrdata <= 32'h00000000;
    end
  end

  logic unused_ok;
  assign unused_ok = power_up_clear | rd_pend | (|hsize) | htrans[0];
endmodule : svs_ctrl

/* bench/svs_properties.sv */
`timescale 1ns/1ps
module svs_properties
  import svs_pkg::*;
(
  input wire logic       clk,
  input wire logic       srst,
  input wire logic       brownout_reset,
  input wire logic       comparator_out,
  input wire logic       use_external_sense,
  input wire logic [3:0] threshold_level,
  input wire logic       supervisor_enable,
  input wire logic       por_request,
  input wire logic       monitor_active,
  input wire logic       low_voltage_flag,
  input wire logic       comparator_level,
  input wire logic       hreadyout,
  input wire logic       hresp
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (srst || brownout_reset);
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  a_off_at_zero: assert property (supervisor_enable == (threshold_level != SVS_SEL_OFF))
    else $error("enable differs from select");
  a_active_needs_on: assert property (monitor_active |-> $past(supervisor_enable))
    else $error("active while off");
  a_external_code: assert property (use_external_sense == (threshold_level == SVS_SEL_EXTERNAL))
    else $error("external sense misrouted");
  a_flag_when_on: assert property ($rose(low_voltage_flag) |-> $past(monitor_active))
    else $error("flag set while not monitoring");
  a_por_when_on: assert property (por_request |-> $past(monitor_active))
    else $error("reset while not monitoring");
  // three cycles of synchroniser latency before the level may be compared
  a_level_live: assert property ($stable(comparator_out) [*4] |-> comparator_level == comparator_out)
    else $error("level not live");
  a_startup_wait: assert property ($rose(supervisor_enable) |=> !monitor_active [*8] ##[1:40] monitor_active)
    else $error("startup delay wrong");
  a_settle_wait: assert property ($changed(threshold_level) && $past(threshold_level) != 4'h0
    && threshold_level != 4'h0 |=> !monitor_active [*4] ##[1:20] monitor_active)
    else $error("settle delay wrong");
endmodule : svs_properties
bind svs_ctrl svs_properties u_prop (.*);

/* bench/svs_comparator_model.sv */
`timescale 1ns/1ps
module svs_comparator_model (
  input  wire logic       supervisor_enable,
  input  wire logic       use_external_sense,
  input  wire logic [3:0] threshold_level,
  input  wire logic [3:0] supply_code,
  input  wire logic       ext_low,
  output logic            comparator_out
);
  // supply_code is the highest threshold that the supply still clears
  always_comb begin
    if (supervisor_enable !== 1'b1) comparator_out = 1'b1;
    else if (use_external_sense) comparator_out = !ext_low;
    else comparator_out = supply_code >= threshold_level;
  end
endmodule : svs_comparator_model

/* bench/svs_ctrl_bench.sv */
`timescale 1ns/1ps
`define CHK(n, e, s) begin compares++; if ((e) !== (s)) begin failures++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end end
module svs_ctrl_bench;
  import svs_pkg::*;
  typedef struct packed {logic [3:0] sel; logic ron; logic xl; logic [3:0] sup;} svs_row_t;
  localparam svs_row_t ROWS [6] = '{10'h040, 10'h169, 10'h163, 10'h38f, 10'h3f0, 10'h3c0};
  logic        clk, srst, brownout_reset, power_up_clear, hsel, hwrite, hreadyout, hresp, low;
  logic        comparator_out, use_external_sense, supervisor_enable, por_request, monitor_active;
  logic        low_voltage_flag, comparator_level, ext_low;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  threshold_level, supply_code;
  logic [31:0] haddr, hwdata, hrdata, rd, cap;
  wire         hready = hreadyout;
  svs_row_t    r;
  int          failures, compares, pors;
  svs_ctrl #(.STARTUP_CYCLES(20), .SETTLE_CYCLES(8)) u_dut (
    .clk(clk), .srst(srst), .brownout_reset(brownout_reset), .power_up_clear(power_up_clear),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .comparator_out(comparator_out), .use_external_sense(use_external_sense),
    .threshold_level(threshold_level), .supervisor_enable(supervisor_enable),
    .por_request(por_request), .monitor_active(monitor_active),
    .low_voltage_flag(low_voltage_flag), .comparator_level(comparator_level));
  svs_comparator_model u_cmp (
    .supervisor_enable(supervisor_enable), .use_external_sense(use_external_sense),
    .threshold_level(threshold_level), .supply_code(supply_code), .ext_low(ext_low),
    .comparator_out(comparator_out));
  always @(posedge clk) if (por_request === 1'b1) pors++;
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task results;
    if (failures == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results
  // read data is taken at the edge where hready is sampled high
  task automatic ready;
    for (int n = 0; n < 20; n++) begin
      @(posedge clk);
      if (hreadyout === 1'b1) begin
        cap = hrdata;
        return;
      end
    end
    failures++;
    results();
  endtask : ready
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= SVS_HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    ready();
    rd = cap;
  endtask : bus
  task automatic active_wait;
    repeat (2) @(posedge clk);
    for (int n = 0; n < 99; n++) begin
      @(negedge clk);
      if (monitor_active === 1'b1) return;
    end
    failures++;
    results();
  endtask : active_wait
  initial begin
    {brownout_reset, power_up_clear, hsel, hwrite, ext_low, srst} = 6'h1;
    {htrans, hsize, haddr, hwdata} = {2'h0, 3'h2, 64'h0};
    supply_code = 4'hf;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    bus(1'b0, SVS_CTRL_ADDR, 32'h0);
    `CHK("reset", 8'h02, rd[7:0])
    for (int i = 0; i < 6; i++) begin
      r = ROWS[i];
      low = (r.sel == SVS_SEL_EXTERNAL) ? r.xl : (r.sup < r.sel);
      supply_code <= 4'hf;
      ext_low <= 1'b0;
      repeat (4) @(posedge clk);
      bus(1'b1, SVS_CTRL_ADDR, {24'h0, r.sel, r.ron, 3'h0});
      active_wait();
      pors = 0;
      supply_code <= r.sup;
      ext_low <= r.xl;
      repeat (8) @(posedge clk);
      bus(1'b0, SVS_CTRL_ADDR, 32'h0);
      `CHK("ctrl", {r.sel, r.ron, 1'b1, !low, low}, rd[7:0])
      `CHK("por", low & r.ron, pors > 0)
    end
    ext_low <= 1'b1;
    repeat (6) @(posedge clk);
    ext_low <= 1'b0;
    repeat (6) @(negedge clk);
    `CHK("sticky", 1'b1, low_voltage_flag)
    @(posedge clk);
    ext_low <= 1'b1;
    repeat (6) @(posedge clk);
    bus(1'b1, SVS_CTRL_ADDR, 32'hf0);
    bus(1'b1, SVS_CTRL_ADDR, 32'h05);
    repeat (4) @(posedge clk);
    bus(1'b0, SVS_CTRL_ADDR, 32'h0);
    `CHK("relatch", 8'h03, rd[7:0])
    supply_code <= 4'hf;
    bus(1'b1, SVS_CTRL_ADDR, 32'h28);
    power_up_clear <= 1'b1;
    repeat (3) @(posedge clk);
    power_up_clear <= 1'b0;
    active_wait();
    bus(1'b0, SVS_CTRL_ADDR, 32'h0);
    `CHK("pu_clear", 8'h2e, rd[7:0])
    brownout_reset <= 1'b1;
    repeat (3) @(posedge clk);
    brownout_reset <= 1'b0;
    bus(1'b0, SVS_CTRL_ADDR, 32'h0);
    `CHK("brownout", 8'h02, rd[7:0])
    supply_code <= 4'h0;
    bus(1'b1, SVS_CTRL_ADDR, 32'h40);
    repeat (4) @(posedge clk);
    bus(1'b0, SVS_CTRL_ADDR, 32'h0);
    `CHK("delay", 8'h40, rd[7:0])
    active_wait();
    bus(1'b1, SVS_CTRL_ADDR + 32'h4, 32'hff);
    bus(1'b0, SVS_CTRL_ADDR + 32'h4, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    bus(1'b0, SVS_CTRL_ADDR, 32'h0);
    `CHK("kept", 4'h4, rd[7:4])
    results();
  end
endmodule : svs_ctrl_bench
